// ---- tb/test_external_if_cache_control.sv ----
// test_external_if_cache_control: self-checking bench for eicc_ctl
// assumes: eicc_pkg compiled first, one 25 MHz clock, inputs at negedge
`timescale 1ns/1ps
module test_external_if_cache_control;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  localparam logic H = 1'b1; // shorthand for table rows
  localparam logic L = 1'b0;
  localparam logic [39:0] CT = 40'hff_fff0_00a8; // cache control
  logic clk = 1'b0;
  logic rst = 1'b1; // full reset
  logic timeoutRst = 1'b0;
  logic regReq = 1'b0, regWrite = 1'b0, regFromSystem = 1'b0;
  logic [39:0] regAddr = 40'h0, memAddr = 40'h0;
  logic [63:0] regWdata = 64'h0;
  logic memValid = 1'b0, memStore = 1'b0, memCacheable = 1'b0;
  logic [63:0] roBase = 64'h0123_4567_89ab_cde0; // read-only contents
  logic [63:0] fillSyndromeIn, scErrStatusIn, scErrAddrIn;
  logic [63:0] bcFillTagIn, eiErrAddrIn, eiErrStatusIn;
  logic regAck, scErrStatusRead, bcCtrlWrite, bcCfgWrite;
  logic [63:0] regRdata, wrData;
  logic [eicc_pkg::NSEL-1:0] regReadStrobe;
  logic forceHit, blockSize64, invalidateAllTags, forcedHit;
  logic [2:0] setEnable;
  logic [3:0] forceBadDataParity;
  logic offChipReq, tagWrite, tagParityCheck, dataParityCheck;
  logic [39:0] tagWriteAddr;
  logic [5:0] tagWriteState;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  // one row per register access: inputs, then expected answer
  // sel of 1ff means the read strobe is not compared
  typedef struct {
    logic w; logic s; logic [39:0] a; logic [63:0] d;
    logic ack; logic [63:0] rd; logic [8:0] sel;
  } eicc_row_t;
  eicc_row_t rows [17];

  // distinct contents so a wrong read mux shows up
  assign fillSyndromeIn = roBase ^ 64'h1;
  assign scErrStatusIn = roBase ^ 64'h2;
  assign scErrAddrIn = roBase ^ 64'h3;
  assign bcFillTagIn = roBase ^ 64'h4;
  assign eiErrAddrIn = roBase ^ 64'h5;
  assign eiErrStatusIn = roBase ^ 64'h6;

  eicc_ctl i_eicc_ctl (
    .clk, .rst, .timeoutRst, .regReq, .regWrite, .regFromSystem,
    .regAddr, .regWdata, .fillSyndromeIn, .scErrStatusIn, .scErrAddrIn,
    .bcFillTagIn, .eiErrAddrIn, .eiErrStatusIn, .memValid, .memStore,
    .memCacheable, .memAddr, .regAck, .regRdata, .scErrStatusRead,
    .regReadStrobe, .bcCtrlWrite, .bcCfgWrite, .wrData, .forceHit,
    .setEnable, .blockSize64, .forceBadDataParity, .invalidateAllTags,
    .forcedHit, .offChipReq, .tagWrite, .tagWriteAddr, .tagWriteState,
    .tagParityCheck, .dataParityCheck
  );

  // ----------------------------------------------------------------
  // clock, hang guard and shared tasks
  // ----------------------------------------------------------------
  always #20 clk = ~clk;

  // about 42 cycles expected, so 1000 means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request stays up; caller lowers it with idle, so back to back works
  task automatic acc(input logic w, input logic s, input logic [39:0] a,
                     input logic [63:0] d);
    regReq = 1'b1;
    regWrite = w;
    regFromSystem = s;
    regAddr = a;
    regWdata = d;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic look(input logic st, input logic ca, input logic [39:0] a);
    memValid = 1'b1;
    memStore = st;
    memCacheable = ca;
    memAddr = a;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic idle();
    regReq = 1'b0;
    memValid = 1'b0;
    @(negedge clk);
  endtask

  // control outputs match bits 0 and 15:8, readback matches all 16 live bits
  task automatic ctl_is(input logic [15:0] v);
    chk(forceHit, v[0]);
    chk(forceBadDataParity, v[11:8]);
    chk(blockSize64, v[12]);
    chk(setEnable, v[15:13]);
    acc(L, L, CT, 64'h0);
    chk(regRdata, {48'h0, v});
  endtask

  task automatic defaults();
    chk(regAck, 1'b0);
    chk(invalidateAllTags, 1'b0);
    chk(tagParityCheck, 1'b1);
    chk(dataParityCheck, 1'b1);
    ctl_is(16'hf000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{H, L, CT, 64'hffff_ffff_ffff_a5fc, H, 64'h0, 9'h000};
    rows[1] = '{L, L, CT, 64'h0, H, 64'ha5fc, 9'h002};
    rows[2] = '{L, L, 40'hff_fff0_0068, 64'h0, H, roBase ^ 64'h1, 9'h001};
    rows[3] = '{L, L, 40'hff_fff0_00e8, 64'h0, H, roBase ^ 64'h2, 9'h004};
    rows[4] = '{L, L, 40'hff_fff0_0108, 64'h0, H, roBase ^ 64'h4, 9'h008};
    rows[5] = '{L, L, 40'hff_fff0_0148, 64'h0, H, roBase ^ 64'h5, 9'h020};
    rows[6] = '{L, L, 40'hff_fff0_0168, 64'h0, H, roBase ^ 64'h6, 9'h040};
    rows[7] = '{L, L, 40'hff_fff0_0188, 64'h0, H, roBase ^ 64'h3, 9'h080};
    rows[8] = '{L, L, 40'hff_fff0_0128, 64'h0, H, 64'h0, 9'h1ff};
    rows[9] = '{L, L, 40'hff_fff0_01c8, 64'h0, H, 64'h0, 9'h1ff};
    rows[10] = '{H, L, 40'hff_fff0_00e8, '1, H, 64'h0, 9'h000};
    // out-of-window addresses and system accesses are never answered
    rows[11] = '{L, L, 40'hfe_fff0_00a8, 64'h0, L, 64'h0, 9'h000};
    rows[12] = '{L, L, 40'h00_fff0_00a8, 64'h0, L, 64'h0, 9'h000};
    rows[13] = '{L, L, 40'hff_ffef_fff8, 64'h0, L, 64'h0, 9'h000};
    rows[14] = '{H, H, CT, 64'h3, L, 64'h0, 9'h000};
    rows[15] = '{L, H, CT, 64'h0, L, 64'h0, 9'h000};
    rows[16] = '{L, L, CT, 64'h0, H, 64'ha5fc, 9'h002};
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    defaults();
    // table of accesses, issued back to back
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].s, rows[i].a, rows[i].d);
      chk(regAck, rows[i].ack);
      chk(regRdata, rows[i].rd);
      if (rows[i].sel !== 9'h1ff) begin
        chk(regReadStrobe, rows[i].sel);
        chk(scErrStatusRead, rows[i].sel[2]);
      end
    end
    idle();
    ctl_is(16'ha5fc);
    // flush pulses on every write of one, not on zero
    acc(H, L, CT, 64'h2002); // tag state kept zero
    chk(invalidateAllTags, 1'b1);
    acc(H, L, CT, 64'h2002);
    chk(invalidateAllTags, 1'b1);
    acc(H, L, CT, 64'h2000);
    chk(invalidateAllTags, 1'b0);
    // force-hit with one set and an odd-looking tag state of 2d
    acc(H, L, CT, 64'h20b5); // only set 0 enabled
    idle();
    chk(tagParityCheck, 1'b0);
    chk(dataParityCheck, 1'b0);
    look(H, H, 40'h12_3456_7880);
    chk(forcedHit, 1'b1);
    chk(offChipReq, 1'b0);
    chk(tagWrite, 1'b1);
    chk(tagWriteAddr, 40'h12_3456_7880);
    chk(tagWriteState, 6'h2d);
    look(L, H, 40'h00_0000_0040);
    chk(forcedHit, 1'b1);
    chk(tagWrite, 1'b0);
    chk(tagWriteAddr, 40'h12_3456_7880);
    look(H, L, 40'h00_0000_0080);
    chk(forcedHit, 1'b0);
    chk(offChipReq, 1'b1);
    chk(tagWrite, 1'b0);
    idle();
    // timeout reset must leave the control register alone
    timeoutRst = 1'b1;
    @(negedge clk);
    timeoutRst = 1'b0;
    chk(regAck, 1'b0);
    ctl_is(16'h20b5);
    // leaving force-hit: tag state no longer applied
    acc(H, L, CT, 64'h20b4);
    idle();
    look(H, H, 40'h00_0000_00c0);
    chk(forcedHit, 1'b0);
    chk(tagWrite, 1'b0);
    chk(tagParityCheck, 1'b1);
    // write-only board registers give strobes and data
    // bit 1 stays clear so later reads are legal
    acc(H, L, 40'hff_fff0_0128, 64'h0000_00c0_ffee_0010);
    chk(bcCtrlWrite, 1'b1);
    chk(bcCfgWrite, 1'b0);
    chk(wrData, 64'h0000_00c0_ffee_0010);
    acc(H, L, 40'hff_fff0_01c8, 64'h0000_0000_0bad_f00c);
    chk(bcCfgWrite, 1'b1);
    chk(bcCtrlWrite, 1'b0);
    chk(wrData, 64'h0000_0000_0bad_f00c);
    idle();
    // second full reset in mid-run restores every default
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    defaults();
    idle();
    complete_run();
  end
endmodule // test_external_if_cache_control

// ---- verilog/eicc_addr_decode.sv ----
// eicc_addr_decode: turns a physical address into a one-hot register select
// assumes: address stable while the request is presented, same clock domain
`timescale 1ns/1ps
module eicc_addr_decode (
  addr,
  inWindow,
  sel
);
  input wire logic [eicc_pkg::ADDR_W-1:0] addr; // request address
  output logic inWindow;                         // inside reserved window
  output logic [eicc_pkg::NSEL-1:0] sel;         // one-hot register select

  // ----------------------------------------------------------------
  // exact match helper
  // ----------------------------------------------------------------
  function automatic logic hitAt(input logic [39:0] a, input logic [39:0] b);
    hitAt = (a == b);
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // window check is inclusive at both ends [RULE_02]
  always_comb begin
    inWindow = (addr >= eicc_pkg::WIN_BASE) && (addr <= eicc_pkg::WIN_LAST);
    sel = '0;
    sel[eicc_pkg::SEL_FSYND] = hitAt(addr, eicc_pkg::ADDR_FSYND);
    sel[eicc_pkg::SEL_SC_CTRL] = hitAt(addr, eicc_pkg::ADDR_SC_CTRL);
    sel[eicc_pkg::SEL_SC_ESTAT] = hitAt(addr, eicc_pkg::ADDR_SC_ESTAT);
    sel[eicc_pkg::SEL_BC_FTAG] = hitAt(addr, eicc_pkg::ADDR_BC_FTAG);
    sel[eicc_pkg::SEL_BC_CTRL] = hitAt(addr, eicc_pkg::ADDR_BC_CTRL);
    sel[eicc_pkg::SEL_EI_EADDR] = hitAt(addr, eicc_pkg::ADDR_EI_EADDR);
    sel[eicc_pkg::SEL_EI_ESTAT] = hitAt(addr, eicc_pkg::ADDR_EI_ESTAT);
    sel[eicc_pkg::SEL_SC_EADDR] = hitAt(addr, eicc_pkg::ADDR_SC_EADDR);
    sel[eicc_pkg::SEL_BC_CFG] = hitAt(addr, eicc_pkg::ADDR_BC_CFG);
  end

endmodule // eicc_addr_decode

// ---- verilog/eicc_ctl.sv ----
// eicc_ctl: register decode for the external interface unit and the
// second cache control register with force-hit, flush and tag state
// assumes: one clock, requests and lookups from same-clock logic,
// error registers live elsewhere and are passed in for readback
//
// Overview of operation
// [RULE_01] system-side accesses never reach these registers
// [RULE_02] decode only inside reserved one-megabyte window
// [RULE_03] software avoids undefined addresses in window
// [RULE_04] cache control, status, address decoded at offsets
// [RULE_05] board registers write-only, others read-only
// [RULE_06] software keeps board control bit1 zero
// [RULE_07] full reset loads defaults, timeout reset keeps
// [RULE_08] force-hit makes cacheable accesses hit
// [RULE_09] noncacheable still goes off chip
// [RULE_10] software enables exactly one set first
// [RULE_11] force-hit disables tag and data parity
// [RULE_12] forced store writes tag and state
// [RULE_13] writing flush one clears all valids
// [RULE_14] tag state field bits 7:2, reset zero
// [RULE_15] even parity correct, written parity verbatim
// [RULE_16] software keeps tag state zero normally
// [RULE_17] state bits: parity,valid,shared,dirty,two modified
// [RULE_18] set enable bits 15:13, reset all enabled
// [RULE_19] control read returns stored fields
`timescale 1ns/1ps
module eicc_ctl (
  clk,
  rst,
  timeoutRst,
  regReq,
  regWrite,
  regFromSystem,
  regAddr,
  regWdata,
  fillSyndromeIn,
  scErrStatusIn,
  scErrAddrIn,
  bcFillTagIn,
  eiErrAddrIn,
  eiErrStatusIn,
  memValid,
  memStore,
  memCacheable,
  memAddr,
  regAck,
  regRdata,
  scErrStatusRead,
  regReadStrobe,
  bcCtrlWrite,
  bcCfgWrite,
  wrData,
  forceHit,
  setEnable,
  blockSize64,
  forceBadDataParity,
  invalidateAllTags,
  forcedHit,
  offChipReq,
  tagWrite,
  tagWriteAddr,
  tagWriteState,
  tagParityCheck,
  dataParityCheck
);
  // ----------------------------------------------------------------
  // ports
  // ----------------------------------------------------------------
  input wire logic clk;
  input wire logic rst;                 // full reset
  input wire logic timeoutRst;          // timeout reset
  input wire logic regReq;              // register access request
  input wire logic regWrite;            // access is a write
  input wire logic regFromSystem;       // access arrived from the system
  input wire logic [39:0] regAddr;      // access address
  input wire logic [63:0] regWdata;     // write data
  input wire logic [63:0] fillSyndromeIn;
  input wire logic [63:0] scErrStatusIn;
  input wire logic [63:0] scErrAddrIn;
  input wire logic [63:0] bcFillTagIn;
  input wire logic [63:0] eiErrAddrIn;
  input wire logic [63:0] eiErrStatusIn;
  input wire logic memValid;            // cache lookup request
  input wire logic memStore;
  input wire logic memCacheable;
  input wire logic [39:0] memAddr;
  output logic regAck;                  // access answered
  output logic [63:0] regRdata;         // read data
  output logic scErrStatusRead;         // status read, unlock and clear
  output logic [eicc_pkg::NSEL-1:0] regReadStrobe; // per-register read
  output logic bcCtrlWrite;             // board control write strobe
  output logic bcCfgWrite;              // board config write strobe
  output logic [63:0] wrData;           // data for write strobes
  output logic forceHit;
  output logic [2:0] setEnable;
  output logic blockSize64;
  output logic [3:0] forceBadDataParity;
  output logic invalidateAllTags;       // one-cycle flush pulse
  output logic forcedHit;
  output logic offChipReq;
  output logic tagWrite;
  output logic [39:0] tagWriteAddr;
  output logic [5:0] tagWriteState;
  output logic tagParityCheck;
  output logic dataParityCheck;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic inWindow;                       // address inside reserved window
  logic [eicc_pkg::NSEL-1:0] sel;       // one-hot register select
  logic procAcc;                        // accepted processor access
  logic rdAcc;                          // accepted read
  logic wrAcc;                          // accepted write
  logic flushBit;                       // stored flush bit
  logic [5:0] forcedTagState;           // stored forced tag state
  logic [63:0] ctlValue;                // control register image
  logic [63:0] next_rdata;              // read mux result

  eicc_addr_decode u_decode (
    .addr(regAddr),
    .inWindow(inWindow),
    .sel(sel)
  );

  // system requests are dropped before decode [RULE_01]
  assign procAcc = regReq && !regFromSystem && inWindow; // [RULE_02]
  assign rdAcc = procAcc && !regWrite;
  assign wrAcc = procAcc && regWrite;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // only full reset loads defaults; timeout reset leaves it [RULE_07]
  always_ff @(posedge clk) begin
    if (rst) begin
      forceHit <= 1'b0; // [RULE_08]
      flushBit <= 1'b0; // [RULE_13]
      forcedTagState <= eicc_pkg::TSTAT_RST; // [RULE_14]
      forceBadDataParity <= eicc_pkg::FBDP_RST;
      blockSize64 <= eicc_pkg::BLK_RST;
      setEnable <= eicc_pkg::SETEN_RST; // [RULE_18]
    end else if (wrAcc && sel[eicc_pkg::SEL_SC_CTRL]) begin // [RULE_04]
      forceHit <= regWdata[eicc_pkg::FHIT_BIT];
      flushBit <= regWdata[eicc_pkg::FLUSH_BIT];
      forcedTagState <= regWdata[eicc_pkg::TSTAT_HI:eicc_pkg::TSTAT_LO];
      forceBadDataParity <= regWdata[eicc_pkg::FBDP_HI:eicc_pkg::FBDP_LO];
      blockSize64 <= regWdata[eicc_pkg::BLK_BIT];
      setEnable <= regWdata[eicc_pkg::SETEN_HI:eicc_pkg::SETEN_LO];
    end
  end

  // flush fires on every write of one, not on a held one [RULE_13]
  always_ff @(posedge clk) begin
    if (rst) begin
      invalidateAllTags <= 1'b0;
    end else begin
      invalidateAllTags <= wrAcc && sel[eicc_pkg::SEL_SC_CTRL]
        && regWdata[eicc_pkg::FLUSH_BIT];
    end
  end

  // readback image, reserved bits read zero [RULE_19]
  always_comb begin
    ctlValue = eicc_pkg::ZERO64;
    ctlValue[eicc_pkg::FHIT_BIT] = forceHit;
    ctlValue[eicc_pkg::FLUSH_BIT] = flushBit;
    ctlValue[eicc_pkg::TSTAT_HI:eicc_pkg::TSTAT_LO] = forcedTagState;
    ctlValue[eicc_pkg::FBDP_HI:eicc_pkg::FBDP_LO] = forceBadDataParity;
    ctlValue[eicc_pkg::BLK_BIT] = blockSize64;
    ctlValue[eicc_pkg::SETEN_HI:eicc_pkg::SETEN_LO] = setEnable;
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // write-only and undefined addresses read zero; undefined ones are
  // still answered so the pipe never hangs on a stray access [RULE_05]
  always_comb begin
    next_rdata = eicc_pkg::ZERO64;
    if (sel[eicc_pkg::SEL_SC_CTRL]) begin
      next_rdata = ctlValue; // [RULE_19]
    end else if (sel[eicc_pkg::SEL_SC_ESTAT]) begin
      next_rdata = scErrStatusIn; // [RULE_04]
    end else if (sel[eicc_pkg::SEL_SC_EADDR]) begin
      next_rdata = scErrAddrIn; // [RULE_04]
    end else if (sel[eicc_pkg::SEL_FSYND]) begin
      next_rdata = fillSyndromeIn; // [RULE_05]
    end else if (sel[eicc_pkg::SEL_BC_FTAG]) begin
      next_rdata = bcFillTagIn; // [RULE_05]
    end else if (sel[eicc_pkg::SEL_EI_EADDR]) begin
      next_rdata = eiErrAddrIn; // [RULE_05]
    end else if (sel[eicc_pkg::SEL_EI_ESTAT]) begin
      next_rdata = eiErrStatusIn; // [RULE_05]
    end
  end

  // ----------------------------------------------------------------
  // answer and side-effect strobes
  // ----------------------------------------------------------------
  // timeout reset drops a pending answer but not the control state
  always_ff @(posedge clk) begin
    if (rst || timeoutRst) begin
      regAck <= 1'b0;
      regRdata <= eicc_pkg::ZERO64;
    end else begin
      regAck <= procAcc; // [RULE_01]
      regRdata <= rdAcc ? next_rdata : eicc_pkg::ZERO64;
    end
  end

  // read strobes; a status read unlocks and clears it downstream
  always_ff @(posedge clk) begin
    if (rst || timeoutRst) begin
      regReadStrobe <= '0;
      scErrStatusRead <= 1'b0;
    end else begin
      regReadStrobe <= rdAcc ? sel : '0;
      scErrStatusRead <= rdAcc && sel[eicc_pkg::SEL_SC_ESTAT];
    end
  end

  // write-only board registers are forwarded as strobes [RULE_05]
  always_ff @(posedge clk) begin
    if (rst || timeoutRst) begin
      bcCtrlWrite <= 1'b0;
      bcCfgWrite <= 1'b0;
      wrData <= eicc_pkg::ZERO64;
    end else begin
      bcCtrlWrite <= wrAcc && sel[eicc_pkg::SEL_BC_CTRL];
      bcCfgWrite <= wrAcc && sel[eicc_pkg::SEL_BC_CFG];
      if (wrAcc) begin
        wrData <= regWdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // lookup steering
  // ----------------------------------------------------------------
  eicc_tag_gen u_tag (
    .clk(clk),
    .rst(rst),
    .memValid(memValid),
    .memStore(memStore),
    .memCacheable(memCacheable),
    .memAddr(memAddr),
    .forceHit(forceHit),
    .forcedTagState(forcedTagState),
    .forcedHit(forcedHit),
    .offChipReq(offChipReq),
    .tagWrite(tagWrite),
    .tagWriteAddr(tagWriteAddr),
    .tagWriteState(tagWriteState),
    .tagParityCheck(tagParityCheck),
    .dataParityCheck(dataParityCheck)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cbc @(posedge clk); endclocking
  default disable iff (rst);

  sequence ctlFlushWr;
    wrAcc && sel[eicc_pkg::SEL_SC_CTRL] && regWdata[eicc_pkg::FLUSH_BIT];
  endsequence
  sequence flushPulse;
    invalidateAllTags ##1 !invalidateAllTags;
  endsequence

  system_block_a: assert property ( // [RULE_01]
    regReq && regFromSystem |=> !regAck && $stable(ctlValue))
    else $error("system access reached the registers");
  window_ack_a: assert property ( // [RULE_02]
    regReq && !regFromSystem && !inWindow && !timeoutRst |=> !regAck)
    else $error("access outside window answered");
  ctl_read_a: assert property ( // [RULE_19]
    rdAcc && sel[eicc_pkg::SEL_SC_CTRL] && !timeoutRst
      |=> regAck && regRdata == $past(ctlValue))
    else $error("control readback mismatch");
  board_strobe_a: assert property ( // [RULE_05]
    wrAcc && sel[eicc_pkg::SEL_BC_CFG] && !timeoutRst
      |=> bcCfgWrite && wrData == $past(regWdata) && regRdata == '0)
    else $error("board config write not forwarded");
  timeout_keep_a: assert property ( // [RULE_07]
    timeoutRst && !wrAcc |=> $stable(ctlValue))
    else $error("timeout reset changed control register");
  flush_once_a: assert property ( // [RULE_13]
    ctlFlushWr ##1 !ctlFlushWr |-> flushPulse)
    else $error("flush pulse wrong length");
  force_hit_a: assert property ( // [RULE_08]
    memValid && memCacheable && forceHit |=> forcedHit)
    else $error("cacheable access not forced to hit");
  full_reset_a: assert property ( // [RULE_18]
    @(posedge clk) disable iff (1'b0)
    rst |=> setEnable == eicc_pkg::SETEN_RST && !forceHit
      && forcedTagState == eicc_pkg::TSTAT_RST && !invalidateAllTags)
    else $error("full reset defaults wrong");

endmodule // eicc_ctl

// ---- verilog/eicc_pkg.sv ----
// eicc_pkg: constants shared by the external-interface cache control block
// assumes: 40-bit physical addresses and 64-bit register data
package eicc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 40; // physical address width
  localparam int DATA_W = 64; // register data width
  localparam int NSEL = 9;    // number of decoded registers

  // ----------------------------------------------------------------
  // reserved window and register addresses
  // ----------------------------------------------------------------
  localparam logic [39:0] WIN_BASE = 40'hff_fff0_0000; // window bottom
  localparam logic [39:0] WIN_LAST = 40'hff_ffff_ffff; // window top
  localparam logic [39:0] ADDR_FSYND = 40'hff_fff0_0068;
  localparam logic [39:0] ADDR_SC_CTRL = 40'hff_fff0_00a8;
  localparam logic [39:0] ADDR_SC_ESTAT = 40'hff_fff0_00e8;
  localparam logic [39:0] ADDR_BC_FTAG = 40'hff_fff0_0108;
  localparam logic [39:0] ADDR_BC_CTRL = 40'hff_fff0_0128;
  localparam logic [39:0] ADDR_EI_EADDR = 40'hff_fff0_0148;
  localparam logic [39:0] ADDR_EI_ESTAT = 40'hff_fff0_0168;
  localparam logic [39:0] ADDR_SC_EADDR = 40'hff_fff0_0188;
  localparam logic [39:0] ADDR_BC_CFG = 40'hff_fff0_01c8;

  // ----------------------------------------------------------------
  // one-hot select positions
  // ----------------------------------------------------------------
  localparam int SEL_FSYND = 0;
  localparam int SEL_SC_CTRL = 1;
  localparam int SEL_SC_ESTAT = 2;
  localparam int SEL_BC_FTAG = 3;
  localparam int SEL_BC_CTRL = 4;
  localparam int SEL_EI_EADDR = 5;
  localparam int SEL_EI_ESTAT = 6;
  localparam int SEL_SC_EADDR = 7;
  localparam int SEL_BC_CFG = 8;

  // ----------------------------------------------------------------
  // second cache control fields and reset values
  // ----------------------------------------------------------------
  localparam int FHIT_BIT = 0;  // force hit
  localparam int FLUSH_BIT = 1; // invalidate all tags
  localparam int TSTAT_LO = 2;  // forced tag state low
  localparam int TSTAT_HI = 7;  // forced tag state high
  localparam int FBDP_LO = 8;   // force bad data parity low
  localparam int FBDP_HI = 11;  // force bad data parity high
  localparam int BLK_BIT = 12;  // block size select
  localparam int SETEN_LO = 13; // set enable low
  localparam int SETEN_HI = 15; // set enable high
  localparam logic [5:0] TSTAT_RST = 6'h00;
  localparam logic [3:0] FBDP_RST = 4'h0;
  localparam logic BLK_RST = 1'h1;
  localparam logic [2:0] SETEN_RST = 3'h7;
  localparam logic [63:0] ZERO64 = 64'h0;

endpackage

// ---- verilog/eicc_tag_gen.sv ----
// eicc_tag_gen: lookup steering for the second cache under force-hit mode
// assumes: one lookup request per cycle from the memory pipe, same clock
`timescale 1ns/1ps
module eicc_tag_gen (
  clk,
  rst,
  memValid,
  memStore,
  memCacheable,
  memAddr,
  forceHit,
  forcedTagState,
  forcedHit,
  offChipReq,
  tagWrite,
  tagWriteAddr,
  tagWriteState,
  tagParityCheck,
  dataParityCheck
);
  input wire logic clk;
  input wire logic rst;
  input wire logic memValid;          // lookup request
  input wire logic memStore;          // request is a store
  input wire logic memCacheable;      // request is cacheable
  input wire logic [39:0] memAddr;    // request address
  input wire logic forceHit;          // force-hit mode
  input wire logic [5:0] forcedTagState;
  output logic forcedHit;             // lookup forced to hit
  output logic offChipReq;            // request goes off chip
  output logic tagWrite;              // forced tag write strobe
  output logic [39:0] tagWriteAddr;   // tag taken from store address
  output logic [5:0] tagWriteState;   // parity,valid,shared,dirty,ow1,ow0
  output logic tagParityCheck;        // tag parity checking enabled
  output logic dataParityCheck;       // data parity checking enabled

  logic fhCache; // cacheable lookup in force-hit mode
  assign fhCache = memValid && memCacheable && forceHit;

  // ----------------------------------------------------------------
  // hit forcing and off-chip routing
  // ----------------------------------------------------------------
  // noncacheable traffic never forced, always off chip [RULE_08] [RULE_09]
  always_ff @(posedge clk) begin
    if (rst) begin
      forcedHit <= 1'b0;
      offChipReq <= 1'b0;
    end else begin
      forcedHit <= fhCache; // [RULE_08]
      offChipReq <= memValid && !memCacheable; // [RULE_09]
    end
  end

  // ----------------------------------------------------------------
  // forced tag write on stores
  // ----------------------------------------------------------------
  // state written verbatim, even a bad parity bit [RULE_12] [RULE_15]
  always_ff @(posedge clk) begin
    if (rst) begin
      tagWrite <= 1'b0;
      tagWriteAddr <= '0;
      tagWriteState <= '0;
    end else begin
      tagWrite <= fhCache && memStore; // [RULE_12]
      if (fhCache && memStore) begin
        tagWriteAddr <= memAddr; // [RULE_12]
        tagWriteState <= forcedTagState; // [RULE_17] [RULE_14]
      end
    end
  end

  // ----------------------------------------------------------------
  // parity checking gate
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tagParityCheck <= 1'b1;
      dataParityCheck <= 1'b1;
    end else begin
      tagParityCheck <= !forceHit; // [RULE_11]
      dataParityCheck <= !forceHit; // [RULE_11]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  noncache_route_a: assert property ( // [RULE_09]
    memValid && !memCacheable |=> offChipReq && !forcedHit)
    else $error("noncacheable request forced or kept on chip");
  tag_write_a: assert property ( // [RULE_12]
    fhCache && memStore |=> tagWrite && tagWriteAddr == $past(memAddr)
      && tagWriteState == $past(forcedTagState))
    else $error("forced store tag write wrong");
  parity_gate_a: assert property ( // [RULE_11]
    forceHit |=> !tagParityCheck && !dataParityCheck)
    else $error("parity checking left on in force-hit mode");

endmodule // eicc_tag_gen
